// [verification/rspi_host.sv]
// Purpose: host serial master driving frames into the port
// Assumes: sclk rests low, 160 ns period
// Notes: read bits are taken after each falling edge
`timescale 1ns/10ps
module rspi_host
(
  output logic sclk,
  output logic chip_select_n,
  output logic serial_in,
  input wire logic so_pin
);
  logic [7:0] tx [4];
  logic [7:0] rx [4];
  logic held;
  logic idle;
  // idle lines at time zero
  initial
  begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    serial_in = 1'b0;
  end
  // one frame: command byte then n data bytes, msb first
  task automatic run(input logic [7:0] cmd, input int n);
    logic [7:0] b;
    chip_select_n = 1'b0;
    for (int i = 0; i <= n; i++)
    begin
      b = (i == 0) ? cmd : tx[i-1];
      for (int k = 7; k >= 0; k--)
      begin
        serial_in = b[k];
        #40 sclk = 1'b1;
        #80 sclk = 1'b0;
        #40 if (i > 0) rx[i-1][k] = so_pin;
      end
    end
    #200 held = so_pin;
    chip_select_n = 1'b1;
    serial_in = ~serial_in; // no stale value once released
    #80 idle = so_pin;
  endtask
endmodule

// [verification/rspi_port_sva.sv]
// Purpose: clk-side port checks of the serial register port
// Assumes: pins sampled on rising clk
// Notes: serial bit timing is judged by the bench
`timescale 1ns/10ps
module rspi_port_sva
  import rspi_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic chip_select_n,
  input wire logic power_off_pin,
  input wire logic serial_out_oe_n,
  input wire logic [7:0] mode_ctrl,
  input wire logic port_powered
);
  // ----
  // properties
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_oe_desel: assert property (chip_select_n |-> serial_out_oe_n)
    else $error("output driven while deselected");
  chk_oe_off: assert property (power_off_pin |-> serial_out_oe_n)
    else $error("output driven in shutdown");
  chk_rst_mode: assert property (disable iff (1'b0) rst |=> mode_ctrl == RSPI_MODE_RST)
    else $error("mode not ready after reset");
  chk_rst_pwr: assert property (disable iff (1'b0) rst |=> !port_powered)
    else $error("powered during reset");
  chk_off_pwr: assert property (power_off_pin [*3] |=> !port_powered)
    else $error("powered in shutdown");
  chk_on_pwr: assert property (!power_off_pin [*4] |-> port_powered)
    else $error("not powered after shutdown left");
  chk_off_mode: assert property (power_off_pin [*6] |-> mode_ctrl == RSPI_MODE_RST)
    else $error("mode kept through shutdown");
  // mode may only move after a frame, so a long idle stretch must be quiet
  chk_mode_idle: assert property ((chip_select_n && !power_off_pin) [*8] |-> $stable(mode_ctrl))
    else $error("mode changed without a write");
endmodule
bind rspi_port rspi_port_sva rspi_port_sva_i (.clk(clk), .rst(rst),
  .chip_select_n(chip_select_n), .power_off_pin(power_off_pin),
  .serial_out_oe_n(serial_out_oe_n), .mode_ctrl(mode_ctrl), .port_powered(port_powered));

// [verification/test_radio_spi_register_port.sv]
// Purpose: self-checking bench of the serial register port
// Assumes: host model issues frames
// Notes: pull-up modelled on the output pin
`timescale 1ns/10ps
module test_radio_spi_register_port;
  import rspi_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic power_off_pin = 1'b0;
  logic sclk, chip_select_n, serial_in, serial_out, serial_out_oe_n, port_powered, so_pin;
  logic [7:0] mode_ctrl;
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;
  // ----
  // wiring
  // ----
  assign so_pin = serial_out_oe_n ? 1'b1 : serial_out; // pull-up when released
  always #50 clk = ~clk;
  rspi_port rspi_port_i (.clk(clk), .rst(rst), .sclk(sclk), .chip_select_n(chip_select_n),
    .serial_in(serial_in), .power_off_pin(power_off_pin), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n), .mode_ctrl(mode_ctrl), .port_powered(port_powered));
  rspi_host rspi_host_i (.sclk(sclk), .chip_select_n(chip_select_n), .serial_in(serial_in),
    .so_pin(so_pin));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard, far above the few hundred cycles used
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      print_verdict();
    end
  end
  // ----
  // scenarios
  // ----
  task automatic t_burst();
    rspi_host_i.tx = '{8'ha5, 8'h3c, 8'hc2, 8'h00};
    rspi_host_i.run(8'hfe, 3);
    rspi_host_i.tx = '{8'hff, 8'h00, 8'hff, 8'h00};
    rspi_host_i.run(8'h7e, 3);
    chk("reg 7e", 8'ha5, rspi_host_i.rx[0]);
    chk("reg 7f", 8'h3c, rspi_host_i.rx[1]);
    chk("reg 00", 8'hc2, rspi_host_i.rx[2]);
    chk("held bit", 8'h00, {7'h0, rspi_host_i.held});
    chk("idle pin", 8'h01, {7'h0, rspi_host_i.idle});
    $display("t_burst done");
  endtask
  task automatic t_mode();
    rspi_host_i.run(8'h07, 1);
    chk("mode reset", RSPI_MODE_RST, rspi_host_i.rx[0]);
    rspi_host_i.tx[0] = 8'h5a;
    rspi_host_i.run(8'h87, 1);
    repeat (6) @(negedge clk);
    chk("mode out", 8'h5a, mode_ctrl);
    $display("t_mode done");
  endtask
  task automatic t_off();
    @(negedge clk) power_off_pin = 1'b1;
    repeat (8) @(negedge clk);
    chk("mode off", RSPI_MODE_RST, mode_ctrl);
    power_off_pin = 1'b0;
    repeat (4) @(negedge clk);
    chk("powered", 8'h01, {7'h0, port_powered});
    rspi_host_i.run(8'h7f, 2);
    chk("wiped 7f", RSPI_REG_RST, rspi_host_i.rx[0]);
    chk("wiped 00", RSPI_REG_RST, rspi_host_i.rx[1]);
    $display("t_off done");
  endtask
  // reset, then the scenarios in turn
  initial
  begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_mode();
    t_burst();
    t_off();
    print_verdict();
  end
endmodule

// [verilog/rspi_pkg.sv]
// Purpose: shared constants and types for the radio serial register port
// Assumes: 16-bit frames, 7-bit address, 128 byte-wide registers
// Notes: mode codes of the operating mode register are kept as plain values
package rspi_pkg;
  localparam int RSPI_ADDR_W = 7;
  localparam int RSPI_DATA_W = 8;
  localparam int RSPI_NREGS = 128;
  localparam logic [2:0] RSPI_BIT_LAST = 3'h7;
  localparam logic [2:0] RSPI_BIT_RST = 3'h0;
  localparam logic [6:0] RSPI_MODE_ADDR = 7'h07;
  localparam logic [7:0] RSPI_MODE_RST = 8'h01;
  localparam logic [7:0] RSPI_REG_RST = 8'h00;
  localparam logic RSPI_DIR_WRITE = 1'b1;

  typedef enum logic [1:0]
  {
    RSPI_PH_ADDR = 2'b00,
    RSPI_PH_WDATA = 2'b01,
    RSPI_PH_RDATA = 2'b10
  } rspi_phase_t;
endpackage

// [verilog/rspi_port.sv]
// Purpose: serial register port, sixteen-bit frames into 128 byte registers
// Assumes: host is the serial master; serial clock runs only inside frames
// Notes: register file lives in the serial clock domain; power_off_pin and
//        rst wipe it; mode register value is crossed to clk by two flops
`timescale 1ns/10ps

// Notes on behaviour
// - a frame is direction bit, seven address bits, then eight data bits
// - the seven-bit address selects one of 128 byte registers
// - direction bit one means write, zero means read
// - address and each data byte are captured every eight serial clocks
// - serial input is ignored during the data byte of a read
// - read data leaves msb first, one bit per falling serial clock edge
// - after a read the output holds the final data bit until deselect
// - deselect releases the output, the pull-up then reads high
// - continued clocking in a frame bumps the address and moves on
// - in a burst a fresh data byte is taken every eight serial clocks
// - mode changes go through register writes, except shutdown by pin
// - shutdown loses all registers; other modes keep them
// - after reset or leaving shutdown registers reinitialise, mode is ready
module rspi_port
  import rspi_pkg::*;
#(
  parameter int NREGS = RSPI_NREGS
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic serial_in,
  input wire logic power_off_pin,
  output logic serial_out,
  output logic serial_out_oe_n,
  output logic [7:0] mode_ctrl,
  output logic port_powered
);
  // -------------------------------------------------------------
  // link-side state, rising serial clock
  // -------------------------------------------------------------
  typedef struct packed
  {
    rspi_phase_t phase;
    logic [2:0] bit_cnt;
    logic [6:0] shift;
    logic [6:0] addr;
    logic first;
  } rspi_rx_state_t;

  typedef struct packed
  {
    logic [7:0] shreg;
    logic load_pend;
  } rspi_tx_state_t;

  rspi_rx_state_t rx_q;
  rspi_rx_state_t rx_d;
  rspi_tx_state_t tx_q;
  rspi_tx_state_t tx_d;
  logic [7:0] regs [0:NREGS-1];
  logic wr_en;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic link_clr;
  logic rd_load;
  logic [6:0] rd_addr;

  // link clear covers reset, shutdown and idle select; async because sclk stalls
  assign link_clr = rst | power_off_pin | chip_select_n;

  function automatic logic [6:0] rspi_next_addr(input logic [6:0] a);
    rspi_next_addr = a + 7'h01;  // wraps past the top register
  endfunction

  // frame decoder: direction, address, then bytes in a burst
  always_comb
  begin
    rx_d = rx_q;
    wr_en = 1'b0;
    wr_addr = rx_q.addr;
    wr_data = {rx_q.shift, serial_in};
    rd_load = 1'b0;
    rd_addr = rx_q.shift[6:0];
    rx_d.bit_cnt = rx_q.bit_cnt + 3'h1;
    rx_d.shift = {rx_q.shift[5:0], serial_in};
    case (rx_q.phase)
      RSPI_PH_ADDR:
      begin
        if (rx_q.bit_cnt == RSPI_BIT_LAST)
        begin
          rx_d.addr = {rx_q.shift[5:0], serial_in};
          rd_addr = {rx_q.shift[5:0], serial_in};
          rx_d.first = 1'b1;
          if (rx_q.shift[6] == RSPI_DIR_WRITE)
          begin
            rx_d.phase = RSPI_PH_WDATA;
          end
          else
          begin
            rx_d.phase = RSPI_PH_RDATA;
            rd_load = 1'b1;
          end
        end
      end
      RSPI_PH_WDATA:
      begin
        if (rx_q.bit_cnt == RSPI_BIT_LAST)
        begin
          wr_en = 1'b1;
          rx_d.addr = rspi_next_addr(rx_q.addr);
        end
      end
      RSPI_PH_RDATA:
      begin
        // serial_in is shifted but never used while reading
        if (rx_q.bit_cnt == RSPI_BIT_LAST)
        begin
          rx_d.addr = rspi_next_addr(rx_q.addr);
          rd_addr = rspi_next_addr(rx_q.addr);
          rd_load = 1'b1;
        end
      end
      default:
      begin
        rx_d.phase = RSPI_PH_ADDR;
      end
    endcase
  end

  always_ff @(posedge sclk or posedge link_clr)
  begin
    if (link_clr)
    begin
      rx_q.phase <= RSPI_PH_ADDR;
      rx_q.bit_cnt <= RSPI_BIT_RST;
      rx_q.shift <= 7'h00;
      rx_q.addr <= 7'h00;
      rx_q.first <= 1'b0;
    end
    else
    begin
      rx_q <= rx_d;
    end
  end

  // -------------------------------------------------------------
  // register space
  // -------------------------------------------------------------
  logic wipe;
  assign wipe = rst | power_off_pin;

  // byte store; writes land on the rising edge that completes the byte
  // registers clear only on wipe, select toggling leaves them alone
  always_ff @(posedge sclk or posedge wipe)
  begin
    if (wipe)
    begin
      for (int i = 0; i < NREGS; i++)
      begin
        regs[i] <= (i == int'(RSPI_MODE_ADDR)) ? RSPI_MODE_RST : RSPI_REG_RST;
      end
    end
    else if (wr_en && !chip_select_n)
    begin
      regs[wr_addr] <= wr_data;
    end
  end

  // -------------------------------------------------------------
  // output shifter, falling serial clock
  // -------------------------------------------------------------
  // the byte to send is captured on the rising edge that ends the
  // previous byte and held until the falling side takes it one and a half cycles later
  logic [7:0] load_val_q;

  always_ff @(posedge sclk or posedge link_clr)
  begin
    if (link_clr)
    begin
      load_val_q <= 8'h00;
    end
    else if (rd_load)
    begin
      load_val_q <= regs[rd_addr];
    end
  end

  // load on the first falling edge of a data byte, then shift seven times,
  // so the final data bit lands on the last falling edge and stays there
  always_comb
  begin
    tx_d = tx_q;
    tx_d.load_pend = 1'b0;
    if (rx_q.phase == RSPI_PH_RDATA && rx_q.bit_cnt == 3'h1)
    begin
      tx_d.shreg = load_val_q;
    end
    else if (rx_q.phase == RSPI_PH_RDATA)
    begin
      tx_d.shreg = {tx_q.shreg[6:0], tx_q.shreg[0]};
    end
  end

  always_ff @(negedge sclk or posedge link_clr)
  begin
    if (link_clr)
    begin
      tx_q.shreg <= 8'hff;
      tx_q.load_pend <= 1'b0;
    end
    else
    begin
      tx_q <= tx_d;
    end
  end

  // msb drives the pin; the final bit sits there until deselect
  // deselect or shutdown releases the pin to the pull-up
  always_comb
  begin
    serial_out = tx_q.shreg[7];
    serial_out_oe_n = chip_select_n | power_off_pin | rst;
  end

  // -------------------------------------------------------------
  // system side: mode register and power state cross into clk
  // -------------------------------------------------------------
  // mode byte changes on host writes and on wipe; bits are sampled twice and
  // accepted when two samples agree, so a torn multi-bit change is dropped
  typedef struct packed
  {
    logic [7:0] m1;
    logic [7:0] m2;
    logic [7:0] mode;
  } rspi_sys_state_t;

  rspi_sys_state_t sys_q;
  rspi_sys_state_t sys_d;
  logic off_sync;

  rspi_sync #(.RST_VAL(1'b1)) u_off_sync
  (
    .clk(clk),
    .rst(rst),
    .d(power_off_pin),
    .q(off_sync)
  );

  // mode follows writes to the mode register; shutdown forces ready while off_sync is high
  always_comb
  begin
    sys_d.m1 = regs[RSPI_MODE_ADDR];
    sys_d.m2 = sys_q.m1;
    sys_d.mode = sys_q.mode;
    if (off_sync)
    begin
      sys_d.mode = RSPI_MODE_RST;
    end
    else if (sys_q.m2 == sys_q.m1)
    begin
      sys_d.mode = sys_q.m2;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sys_q.m1 <= RSPI_MODE_RST;
      sys_q.m2 <= RSPI_MODE_RST;
      sys_q.mode <= RSPI_MODE_RST;
    end
    else
    begin
      sys_q <= sys_d;
    end
  end

  assign mode_ctrl = sys_q.mode;
  assign port_powered = ~off_sync;
endmodule

// [verilog/rspi_sync.sv]
// Purpose: two-flop synchroniser for a level crossing into a clock domain
// Assumes: destination clock samples the level directly
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps
module rspi_sync
  import rspi_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  typedef struct packed
  {
    logic meta;
    logic sync;
  } rspi_sync_state_t;

  rspi_sync_state_t s_q;
  rspi_sync_state_t s_d;

  // shift the level through two stages
  always_comb
  begin
    s_d.meta = d;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_q.meta <= RST_VAL;
      s_q.sync <= RST_VAL;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign q = s_q.sync;
endmodule
